// ### hdl/mrb_modem_cfg.v
/*
  modem rate and bandwidth configuration bank with a classic wishbone slave,
  plus the small datapath that turns the fields into a decimation ratio,
  a decimation strobe, a symbol rate step and a symbol strobe.
  assumes a wishbone master on i_mclk and the crystal clock as i_mclk.
*/
`timescale 1ns/100ps
`include "mrb_defs.vh"

// Summary of operation
// [RQ1] decimation ratio is 8*(4+bandwidth_mantissa)*2^bandwidth_exponent, sets channel bandwidth
// [RQ2] software never writes both bandwidth fields as zero; unsupported
// [RQ3] 4-bit symbol rate exponent in low nibble of first register, resets 1100
// [RQ4] 8-bit symbol rate mantissa resets 0x22, hidden ninth bit is one
// [RQ5] symbol rate is unsigned float: 9-bit mantissa, 4-bit exponent
// [RQ6] symbol rate is (256+mantissa)*2^exponent/2^28 times crystal frequency
// [RQ7] bit 7 of format register: 0 keeps dc blocking, 1 bypasses it
// [RQ8] software keeps dc blocking up to 250 kbps, reselects if on bypass
// [RQ9] bits 6:4 select modulation: 000 2-fsk, 001 gfsk, 011 ask/ook
// [RQ10] software avoids unassigned modulation codes; behaviour then undefined
// [RQ11] fields read back as written and act on the datapath next cycle
module mrb_modem_cfg (
  // clock and reset
  input  wire                        i_mclk,
  input  wire                        i_rst_b,
  // wishbone slave
  input  wire                        i_wb_cyc,
  input  wire                        i_wb_stb,
  input  wire                        i_wb_we,
  input  wire [15:0]                 i_wb_adr,
  input  wire [3:0]                  i_wb_sel,
  input  wire [31:0]                 i_wb_dat,
  output reg  [31:0]                 o_wb_dat,
  output reg                         o_wb_ack,
  // channel filter
  output wire [1:0]                  o_bandwidth_exponent,
  output wire [1:0]                  o_bandwidth_mantissa,
  output reg  [8:0]                  o_decim_ratio,
  output reg                         o_decim_tick,
  // symbol rate
  output wire [3:0]                  o_symbol_rate_exponent,
  output wire [7:0]                  o_symbol_rate_mantissa,
  output reg  [`MRB_RATE_STEP_W-1:0] o_symbol_rate_step,
  output reg                         o_symbol_tick,
  // demodulator control
  output wire                        o_dc_block_bypass,
  output wire [2:0]                  o_modulation_select,
  output reg                         o_mod_2fsk,
  output reg                         o_mod_gfsk,
  output reg                         o_mod_ask_ook,
  output reg                         o_mod_undefined
);

  reg  [7:0]                  bw_rate_exp_ff;
  reg  [7:0]                  rate_mant_ff;
  reg  [7:0]                  format_ctrl_ff;
  reg  [8:0]                  decim_cnt_ff;
  reg  [`MRB_RATE_ACC_W-1:0]  rate_acc_ff;
  reg  [7:0]                  nxt_bw_rate_exp;
  reg  [7:0]                  nxt_rate_mant;
  reg  [7:0]                  nxt_format_ctrl;
  reg  [31:0]                 nxt_rd_dat;
  reg  [8:0]                  nxt_decim_ratio;
  reg  [`MRB_RATE_STEP_W-1:0] nxt_rate_step;
  reg  [`MRB_RATE_ACC_W:0]    acc_sum;
  wire                        wb_req;
  wire                        wb_wr;
  wire                        hit_bw;
  wire                        hit_mant;
  wire                        hit_fmt;

  // one compare per register; every bank address goes through here
  function addr_hit;
    input [15:0] adr;
    input [15:0] ofs;
    begin
      addr_hit = (adr == ofs);
    end
  endfunction

  // ack one cycle after the request, dropped the cycle after
  assign wb_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_wr    = wb_req & i_wb_we & i_wb_sel[0];
  assign hit_bw   = addr_hit(i_wb_adr, `MRB_ADDR_BW_RATE_EXP);
  assign hit_mant = addr_hit(i_wb_adr, `MRB_ADDR_RATE_MANT);
  assign hit_fmt  = addr_hit(i_wb_adr, `MRB_ADDR_FORMAT_CTRL);

  // field views
  assign o_bandwidth_exponent   = bw_rate_exp_ff[`MRB_BW_EXP_HI:`MRB_BW_EXP_LO];
  assign o_bandwidth_mantissa   = bw_rate_exp_ff[`MRB_BW_MANT_HI:`MRB_BW_MANT_LO];
  assign o_symbol_rate_exponent = bw_rate_exp_ff[`MRB_RATE_EXP_HI:`MRB_RATE_EXP_LO]; // [RQ3]
  assign o_symbol_rate_mantissa = rate_mant_ff;                                     // [RQ4]
  assign o_dc_block_bypass      = format_ctrl_ff[`MRB_DC_BYPASS_BIT];              // [RQ7]
  assign o_modulation_select    = format_ctrl_ff[`MRB_MOD_SEL_HI:`MRB_MOD_SEL_LO];

  // register writes and read mux
  always @* begin
    nxt_bw_rate_exp = bw_rate_exp_ff;
    nxt_rate_mant   = rate_mant_ff;
    nxt_format_ctrl = format_ctrl_ff;
    nxt_rd_dat      = 32'h0000_0000;
    if (wb_wr && hit_bw) begin
      nxt_bw_rate_exp = i_wb_dat[7:0]; // [RQ11]
    end
    if (wb_wr && hit_mant) begin
      nxt_rate_mant = i_wb_dat[7:0]; // [RQ11]
    end
    // manchester and sync mode bits live elsewhere and read as zero here
    if (wb_wr && hit_fmt) begin
      nxt_format_ctrl = i_wb_dat[7:0] & `MRB_FMT_USED_MASK; // [RQ11]
    end
    // unmapped addresses are acked with zero data so the bus never hangs
    if (hit_bw) begin
      nxt_rd_dat = {24'h00_0000, bw_rate_exp_ff};
    end else if (hit_mant) begin
      nxt_rd_dat = {24'h00_0000, rate_mant_ff};
    end else if (hit_fmt) begin
      nxt_rd_dat = {24'h00_0000, format_ctrl_ff};
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      bw_rate_exp_ff <= `MRB_RST_BW_RATE_EXP; // [RQ3]
      rate_mant_ff   <= `MRB_RST_RATE_MANT;   // [RQ4]
      format_ctrl_ff <= `MRB_RST_FORMAT_CTRL;
      o_wb_ack       <= 1'b0;
      o_wb_dat       <= 32'h0000_0000;
    end else begin
      bw_rate_exp_ff <= nxt_bw_rate_exp;
      rate_mant_ff   <= nxt_rate_mant;
      format_ctrl_ff <= nxt_format_ctrl;
      o_wb_ack       <= wb_req;
      if (wb_req) begin
        o_wb_dat <= nxt_rd_dat; // [RQ11]
      end
    end
  end

  // decimation ratio: (4 + m) shifted by 3 + e; 0/0 is not guarded, the
  // ratio of 32 it yields is simply passed on
  always @* begin
    nxt_decim_ratio = {4'h0, {1'b0, o_bandwidth_mantissa} + `MRB_BW_MANT_OFFSET, 2'b00};
    nxt_decim_ratio = {nxt_decim_ratio[7:0], 1'b0};
    nxt_decim_ratio = nxt_decim_ratio << o_bandwidth_exponent; // [RQ1]
  end

  // symbol rate step into a 2^28 phase accumulator on the crystal clock
  always @* begin
    nxt_rate_step = {15'h0000, `MRB_RATE_HIDDEN_ONE, rate_mant_ff}; // [RQ4] [RQ5]
    nxt_rate_step = nxt_rate_step << o_symbol_rate_exponent;       // [RQ6]
    acc_sum       = {1'b0, rate_acc_ff} + {5'h00, o_symbol_rate_step};
  end

  // datapath outputs are registered, so a write is seen one cycle later
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_decim_ratio      <= 9'h000;
      o_decim_tick       <= 1'b0;
      decim_cnt_ff       <= 9'h000;
      o_symbol_rate_step <= {`MRB_RATE_STEP_W{1'b0}};
      rate_acc_ff        <= {`MRB_RATE_ACC_W{1'b0}};
      o_symbol_tick      <= 1'b0;
      o_mod_2fsk         <= 1'b0;
      o_mod_gfsk         <= 1'b0;
      o_mod_ask_ook      <= 1'b0;
      o_mod_undefined    <= 1'b0;
    end else begin
      o_decim_ratio      <= nxt_decim_ratio;    // [RQ1] [RQ11]
      o_symbol_rate_step <= nxt_rate_step;      // [RQ6] [RQ11]
      // a ratio change restarts nothing: the count wraps at the new value
      if (decim_cnt_ff + 9'h001 >= o_decim_ratio) begin
        decim_cnt_ff <= 9'h000;
        o_decim_tick <= (o_decim_ratio != 9'h000); // [RQ1]
      end else begin
        decim_cnt_ff <= decim_cnt_ff + 9'h001;
        o_decim_tick <= 1'b0;
      end
      rate_acc_ff   <= acc_sum[`MRB_RATE_ACC_W-1:0];
      o_symbol_tick <= acc_sum[`MRB_RATE_ACC_W]; // [RQ6]
      o_mod_2fsk      <= 1'b0;
      o_mod_gfsk      <= 1'b0;
      o_mod_ask_ook   <= 1'b0;
      o_mod_undefined <= 1'b0;
      case (o_modulation_select)
        `MRB_MOD_2FSK: begin
          o_mod_2fsk <= 1'b1; // [RQ9]
        end
        `MRB_MOD_GFSK: begin
          o_mod_gfsk <= 1'b1; // [RQ9]
        end
        `MRB_MOD_ASK_OOK: begin
          o_mod_ask_ook <= 1'b1; // [RQ9]
        end
        default: begin
          o_mod_undefined <= 1'b1; // [RQ9]
        end
      endcase
    end
  end

endmodule

// ### include/mrb_defs.vh
/*
  constants for the modem rate and bandwidth configuration bank: byte
  addresses, field positions, reset values and datapath widths.
  assumes inclusion by bare name from the design file.
*/
`ifndef MRB_DEFS_VH
`define MRB_DEFS_VH

// register byte addresses
`define MRB_ADDR_BW_RATE_EXP   16'hdf0c
`define MRB_ADDR_RATE_MANT     16'hdf10
`define MRB_ADDR_FORMAT_CTRL   16'hdf14

// reset values
`define MRB_RST_BW_RATE_EXP    8'h8c
`define MRB_RST_RATE_MANT      8'h22
`define MRB_RST_FORMAT_CTRL    8'h00

// modem_bandwidth_rate_exp fields
`define MRB_BW_EXP_HI          7
`define MRB_BW_EXP_LO          6
`define MRB_BW_MANT_HI         5
`define MRB_BW_MANT_LO         4
`define MRB_RATE_EXP_HI        3
`define MRB_RATE_EXP_LO        0

// modem_format_control fields
`define MRB_DC_BYPASS_BIT      7
`define MRB_MOD_SEL_HI         6
`define MRB_MOD_SEL_LO         4
`define MRB_FMT_USED_MASK      8'hf0

// modulation codes
`define MRB_MOD_2FSK           3'h0
`define MRB_MOD_GFSK           3'h1
`define MRB_MOD_ASK_OOK        3'h3

// bandwidth divisor terms: 8 * (4 + mantissa) * 2^exponent
`define MRB_BW_BASE_MULT       3
`define MRB_BW_MANT_OFFSET     3'h4

// symbol rate: (256 + mantissa) * 2^exponent / 2^28
`define MRB_RATE_HIDDEN_ONE    1'b1
`define MRB_RATE_ACC_W         28
`define MRB_RATE_STEP_W        24

`endif

// ### bench/mrb_modem_cfg_sva.sv
/* checker on the ports of mrb_modem_cfg.
   assumes one clock, synchronous active-low reset, bound below. */
`timescale 1ns/100ps
module mrb_modem_cfg_sva (
  // clock, reset and bus
  input wire logic        i_mclk,
  input wire logic        i_rst_b,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [15:0] i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // fields and datapath
  input wire logic [1:0]  o_bandwidth_exponent,
  input wire logic [1:0]  o_bandwidth_mantissa,
  input wire logic [8:0]  o_decim_ratio,
  input wire logic [3:0]  o_symbol_rate_exponent,
  input wire logic [7:0]  o_symbol_rate_mantissa,
  input wire logic [23:0] o_symbol_rate_step,
  input wire logic        o_dc_block_bypass,
  input wire logic [2:0]  o_modulation_select,
  input wire logic        o_mod_2fsk,
  input wire logic        o_mod_gfsk,
  input wire logic        o_mod_ask_ook
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  wire tk = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr = tk & i_wb_we & i_wb_sel[0];
  AST_ACK: assert property (tk |=> o_wb_ack ##1 !o_wb_ack) else $error("ack");
  AST_EXPF: assert property (wr && i_wb_adr == 16'hdf0c |=>
    {o_bandwidth_exponent, o_bandwidth_mantissa, o_symbol_rate_exponent} ==
    $past(i_wb_dat[7:0])) else $error("f0");
  AST_MANT: assert property (wr && i_wb_adr == 16'hdf10 |=>
    o_symbol_rate_mantissa == $past(i_wb_dat[7:0])) else $error("f1");
  AST_FMT: assert property (wr && i_wb_adr == 16'hdf14 |=>
    {o_dc_block_bypass, o_modulation_select} == $past(i_wb_dat[7:4])) else $error("f2");
  // datapath outputs trail the fields by a cycle, so the first edge after reset is skipped
  AST_DECIM: assert property ($past(i_rst_b) |->
    o_decim_ratio ==
    (9'd8 * (9'd4 + $past(o_bandwidth_mantissa))) << $past(o_bandwidth_exponent))
    else $error("ratio");
  AST_STEP: assert property ($past(i_rst_b) |->
    o_symbol_rate_step ==
    {15'h0, 1'b1, $past(o_symbol_rate_mantissa)} << $past(o_symbol_rate_exponent))
    else $error("step");
  AST_MOD: assert property ($past(i_rst_b) |->
    {o_mod_2fsk, o_mod_gfsk, o_mod_ask_ook} == {$past(o_modulation_select) == 3'h0,
    $past(o_modulation_select) == 3'h1, $past(o_modulation_select) == 3'h3})
    else $error("mod");
  AST_RD: assert property (tk && !i_wb_we && i_wb_adr == 16'hdf10 |=>
    o_wb_dat == {24'h0, o_symbol_rate_mantissa}) else $error("rd");
endmodule
bind mrb_modem_cfg mrb_modem_cfg_sva i_sva (.*);

// ### bench/mrb_modem_cfg_tb_top.sv
/* self-checking bench for mrb_modem_cfg against a register model.
   assumes the checker bind and a one-cycle wishbone answer. */
`timescale 1ns/100ps
module mrb_modem_cfg_tb_top;
  logic        i_mclk, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we, s0;
  logic [15:0] i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic        o_wb_ack, o_decim_tick, o_symbol_tick, o_dc_block_bypass;
  logic        o_mod_2fsk, o_mod_gfsk, o_mod_ask_ook, o_mod_undefined;
  logic [1:0]  o_bandwidth_exponent, o_bandwidth_mantissa;
  logic [8:0]  o_decim_ratio;
  logic [3:0]  o_symbol_rate_exponent;
  logic [7:0]  o_symbol_rate_mantissa, d;
  logic [23:0] o_symbol_rate_step;
  logic [2:0]  o_modulation_select;
  logic [7:0]  mdl [4];
  int          n_mismatch, n_checks, i, j, k, n_tick;
  longint      lo;
  mrb_modem_cfg i_dut (.*);
  initial begin
    i_mclk = 0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic complete_run;
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; an idle edge follows so stb drops for a cycle
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] dt, input logic s);
    int t;
    i_wb_cyc <= 1;
    i_wb_stb <= 1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_sel <= {3'h7, s};
    i_wb_dat <= {24'h0, dt};
    t = 0;
    do begin
      @(posedge i_mclk);
      t++;
    end while (o_wb_ack !== 1'b1 && t < 20);
    if (t >= 20) begin
      n_mismatch++;
      complete_run();
    end
    rd = o_wb_dat;
    i_wb_cyc <= 0;
    i_wb_stb <= 0;
    @(posedge i_mclk);
  endtask
  function automatic logic [31:0] ratio_exp();
    return (8 * (4 + mdl[0][5:4])) << mdl[0][7:6];
  endfunction
  task automatic cmp_all;
    logic [2:0] m;
    for (k = 0; k < 4; k++) begin
      wb(0, 16'hdf0c + 16'(4 * k), 8'h00, 1);
      chk(rd, {24'h0, mdl[k]});
    end
    m = mdl[2][6:4];
    chk(o_decim_ratio, ratio_exp());
    chk({o_bandwidth_exponent, o_bandwidth_mantissa, o_symbol_rate_exponent}, mdl[0]);
    chk(o_symbol_rate_mantissa, mdl[1]);
    chk(o_symbol_rate_step, (256 + mdl[1]) << mdl[0][3:0]);
    chk({o_dc_block_bypass, o_modulation_select}, mdl[2][7:4]);
    chk({o_mod_2fsk, o_mod_gfsk, o_mod_ask_ook, o_mod_undefined},
        {m == 3'h0, m == 3'h1, m == 3'h3, 1'b0});
  endtask
  initial begin
    {n_mismatch, n_checks, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we} = 0;
    {i_wb_adr, i_wb_sel, i_wb_dat} = 0;
    mdl = '{8'h8c, 8'h22, 8'h00, 8'h00};
    void'($urandom(32'h57f92b2c));
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1;
    cmp_all();
    for (i = 0; i < 60; i++) begin
      j = $urandom_range(3);
      d = 8'($urandom);
      s0 = (i % 7 != 0);
      if (j == 0 && d[7:4] == 4'h0) d[6] = 1;
      if (j == 2) d[6:4] = d[5] ? 3'h3 : {2'h0, d[4]};
      // slow symbol rates keep the dc filter on
      if (j == 2 && mdl[0][3:0] < 4'hc) d[7] = 1'b0;
      wb(1, 16'hdf0c + 16'(4 * j), d, s0);
      if (s0 && j < 3) mdl[j] = (j == 2) ? (d & 8'hf0) : d;
      cmp_all();
    end
    // mid-run reset: every field falls back to its reset value
    i_rst_b <= 0;
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1;
    mdl = '{8'h8c, 8'h22, 8'h00, 8'h00};
    cmp_all();
    // largest rate step, so the tick window below sees many carries
    d[7:6] = d[7:6] | 2'h1;
    d[3:0] = 4'hf;
    wb(1, 16'hdf0c, d, 1);
    wb(1, 16'hdf10, 8'hff, 1);
    mdl[0] = d;
    mdl[1] = 8'hff;
    cmp_all();
    for (i = 0; i < 600 && o_decim_tick !== 1'b1; i++) @(posedge i_mclk);
    if (i >= 600) begin
      n_mismatch++;
      complete_run();
    end
    @(posedge i_mclk);
    for (i = 1; i < 600 && o_decim_tick !== 1'b1; i++) @(posedge i_mclk);
    chk(i, ratio_exp());
    n_tick = 0;
    for (i = 0; i < 512; i++) begin
      @(posedge i_mclk);
      n_tick += (o_symbol_tick === 1'b1);
    end
    lo = (longint'(512) * ((256 + mdl[1]) << mdl[0][3:0])) >> 28;
    n_checks++;
    if (n_tick < lo || n_tick > lo + 1) begin
      n_mismatch++;
      $display("ERROR %0t symbol ticks %0d", $time, n_tick);
    end
    complete_run();
  end
endmodule
